// ---- bus_guard_pkg.sv ----
// Purpose: Shared constants, types and the odd parity generator for the bus guard.
// Assumes: Payloads are at most MAX_W bits wide.
// Notes:   Both ends use the same parity function, so they cannot disagree on group layout.
`default_nettype none
package bus_guard_pkg;
  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int GRAN_W  = 64;
  localparam int GROUP_W = 8;
  localparam int MAX_W   = 1024;
  localparam int MAX_CHK = MAX_W / GROUP_W;
  localparam int RESP_W  = 2;
  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    CHK_NONE = 3'h1,
    CHK_DATA = 3'h2,
    CHK_ALL  = 3'h4
  } check_type_e;

  // ----------------------------------------------------------------
  // Odd parity, one check bit per byte, top group may be partial.
  // ----------------------------------------------------------------
  function automatic logic [MAX_CHK-1:0] odd_chk(input logic [MAX_W-1:0] v, input int w);
    logic [MAX_CHK-1:0] p;
    p = '1;
    for (int i = 0; i < MAX_W; i++)
    begin
      if (i < w)
      begin
        p[i / GROUP_W] = p[i / GROUP_W] ^ v[i];
      end
    end
    return p;
  endfunction
endpackage
`default_nettype wire

// ---- bus_guard_if.sv ----
// Purpose: Write data and read data channels with poison and odd parity check signals.
// Assumes: Both ends are built with the same DATA_W.
// Notes:   Check signals are present as wires but driven low when the scheme leaves them out.
`default_nettype none
interface bus_guard_if #(
  parameter int DATA_W = 128
);
  localparam int DCW = DATA_W / bus_guard_pkg::GROUP_W;
  localparam int PW  = (DATA_W + bus_guard_pkg::GRAN_W - 1) / bus_guard_pkg::GRAN_W;
  localparam int PCW = (PW + bus_guard_pkg::GROUP_W - 1) / bus_guard_pkg::GROUP_W;

  logic                              wvalid;
  logic                              wvalid_chk;
  logic                              wready;
  logic                              wready_chk;
  logic [DATA_W-1:0]                 wdata;
  logic [DCW-1:0]                    wdata_chk;
  logic [DCW-1:0]                    wstrb;
  logic [PW-1:0]                     wstrb_chk;
  logic                              wlast;
  logic                              wlast_chk;
  logic [PW-1:0]                     wpoison;
  logic [PCW-1:0]                    wpoison_chk;
  logic                              rvalid;
  logic                              rvalid_chk;
  logic                              rready;
  logic                              rready_chk;
  logic [DATA_W-1:0]                 rdata;
  logic [DCW-1:0]                    rdata_chk;
  logic [bus_guard_pkg::RESP_W-1:0]  rresp;
  logic                              rresp_chk;
  logic                              rlast;
  logic                              rlast_chk;
  logic [PW-1:0]                     rpoison;
  logic [PCW-1:0]                    rpoison_chk;

  modport mst (
    output wvalid, wvalid_chk, wdata, wdata_chk, wstrb, wstrb_chk, wlast, wlast_chk, wpoison, wpoison_chk,
    output rready, rready_chk,
    input  wready, wready_chk,
    input  rvalid, rvalid_chk, rdata, rdata_chk, rresp, rresp_chk, rlast, rlast_chk, rpoison, rpoison_chk
  );

  modport slv (
    input  wvalid, wvalid_chk, wdata, wdata_chk, wstrb, wstrb_chk, wlast, wlast_chk, wpoison, wpoison_chk,
    input  rready, rready_chk,
    output wready, wready_chk,
    output rvalid, rvalid_chk, rdata, rdata_chk, rresp, rresp_chk, rlast, rlast_chk, rpoison, rpoison_chk
  );
endinterface
`default_nettype wire

// ---- bus_guard_master.sv ----
// Purpose: Master end: sends write data with poison and check bits, takes read data and checks it.
// Assumes: DATA_W is a multiple of 8 and matches the interface.
// Notes:   One write beat is held at a time; wr_ready is high while the holding register is empty, except in reset and the first cycle after it.
`default_nettype none
module bus_guard_master #(
  parameter int                         DATA_W     = 128,
  parameter bus_guard_pkg::check_type_e CHECK_TYPE = bus_guard_pkg::CHK_ALL,
  parameter bit                         POISON_EN  = 1'b1
) (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  bus_guard_if.mst                               bus,
  input  wire logic                              wr_valid,
  output var  logic                              wr_ready,
  input  wire logic [DATA_W-1:0]                 wr_data,
  input  wire logic [DATA_W/8-1:0]               wr_strb,
  input  wire logic                              wr_last,
  input  wire logic [(DATA_W+63)/64-1:0]         wr_poison,
  output var  logic                              rd_valid,
  output var  logic [DATA_W-1:0]                 rd_data,
  output var  logic [bus_guard_pkg::RESP_W-1:0]  rd_resp,
  output var  logic                              rd_last,
  output var  logic [(DATA_W+63)/64-1:0]         rd_poison,
  output var  logic                              rd_err
);
  localparam int  DCW  = DATA_W / bus_guard_pkg::GROUP_W;
  localparam int  PW   = (DATA_W + bus_guard_pkg::GRAN_W - 1) / bus_guard_pkg::GRAN_W;
  localparam int  PCW  = (PW + bus_guard_pkg::GROUP_W - 1) / bus_guard_pkg::GROUP_W;
  localparam int  MW   = bus_guard_pkg::MAX_W;
  localparam bit  C_ON = (CHECK_TYPE != bus_guard_pkg::CHK_NONE);
  localparam bit  C_AL = (CHECK_TYPE == bus_guard_pkg::CHK_ALL);

  typedef struct packed {
    logic              wvalid;
    logic              wvalid_chk;
    logic [DATA_W-1:0] wdata;
    logic [DCW-1:0]    wdata_chk;
    logic [DCW-1:0]    wstrb;
    logic [PW-1:0]     wstrb_chk;
    logic              wlast;
    logic              wlast_chk;
    logic [PW-1:0]     wpoison;
    logic [PCW-1:0]    wpoison_chk;
    logic              rready;
    logic              rready_chk;
    logic              wr_ready;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [1:0]        rd_resp;
    logic              rd_last;
    logic [PW-1:0]     rd_poison;
    logic              rd_err;
  } mst_state_s;

  mst_state_s st_reg;
  mst_state_s st_next;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_d;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_s;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_p;
  logic [bus_guard_pkg::MAX_CHK-1:0] r_d;
  logic [bus_guard_pkg::MAX_CHK-1:0] r_p;
  logic [PW-1:0]                     r_pois;
  logic                              hs_bad;
  logic                              pay_bad;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    if (st_reg.wvalid && bus.wready)
    begin
      st_next.wvalid = 1'b0;
    end
    if (wr_valid && st_reg.wr_ready)
    begin
      st_next.wvalid  = 1'b1;
      st_next.wdata   = wr_data;
      st_next.wstrb   = wr_strb;
      st_next.wlast   = wr_last;
      st_next.wpoison = POISON_EN ? wr_poison : '0;
    end
    st_next.wr_ready = !st_next.wvalid;
    st_next.rready   = 1'b1;
    e_d = bus_guard_pkg::odd_chk(MW'(st_next.wdata), DATA_W);
    e_s = bus_guard_pkg::odd_chk(MW'(st_next.wstrb), DCW);
    e_p = bus_guard_pkg::odd_chk(MW'(st_next.wpoison), PW);
    st_next.wvalid_chk  = C_AL ? !st_next.wvalid : 1'b0;
    st_next.rready_chk  = C_AL ? !st_next.rready : 1'b0;
    st_next.wdata_chk   = C_ON ? e_d[DCW-1:0] : '0;
    st_next.wstrb_chk   = C_AL ? e_s[PW-1:0] : '0;
    st_next.wlast_chk   = C_AL ? !st_next.wlast : 1'b0;
    st_next.wpoison_chk = (C_AL && POISON_EN) ? e_p[PCW-1:0] : '0;
    r_pois  = POISON_EN ? bus.rpoison : '0;
    r_d     = bus_guard_pkg::odd_chk(MW'(bus.rdata), DATA_W);
    r_p     = bus_guard_pkg::odd_chk(MW'(r_pois), PW);
    hs_bad  = C_AL && ((bus.rvalid_chk == bus.rvalid) || (bus.wready_chk == bus.wready));
    pay_bad = (C_ON && (bus.rdata_chk != r_d[DCW-1:0]))
           || (C_AL && ((bus.rresp_chk == ^bus.rresp) || (bus.rlast_chk == bus.rlast)))
           || (C_AL && POISON_EN && (bus.rpoison_chk != r_p[PCW-1:0]));
    st_next.rd_err = hs_bad || (bus.rvalid && pay_bad);
    if (bus.rvalid && st_reg.rready)
    begin
      st_next.rd_valid  = 1'b1;
      st_next.rd_data   = bus.rdata;
      st_next.rd_resp   = bus.rresp;
      st_next.rd_last   = bus.rlast;
      st_next.rd_poison = r_pois;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg            <= '0;
      st_reg.wvalid_chk <= C_AL;
      st_reg.rready_chk <= C_AL;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus.wvalid      = st_reg.wvalid;
  assign bus.wvalid_chk  = st_reg.wvalid_chk;
  assign bus.wdata       = st_reg.wdata;
  assign bus.wdata_chk   = st_reg.wdata_chk;
  assign bus.wstrb       = st_reg.wstrb;
  assign bus.wstrb_chk   = st_reg.wstrb_chk;
  assign bus.wlast       = st_reg.wlast;
  assign bus.wlast_chk   = st_reg.wlast_chk;
  assign bus.wpoison     = st_reg.wpoison;
  assign bus.wpoison_chk = st_reg.wpoison_chk;
  assign bus.rready      = st_reg.rready;
  assign bus.rready_chk  = st_reg.rready_chk;
  assign wr_ready        = st_reg.wr_ready;
  assign rd_valid        = st_reg.rd_valid;
  assign rd_data         = st_reg.rd_data;
  assign rd_resp         = st_reg.rd_resp;
  assign rd_last         = st_reg.rd_last;
  assign rd_poison       = st_reg.rd_poison;
  assign rd_err          = st_reg.rd_err;
endmodule // bus_guard_master
`default_nettype wire

// ---- bus_guard_slave.sv ----
// Purpose: Slave end: checks write data parity, gathers poison per granule, returns read data.
// Assumes: DATA_W is a multiple of 8 and matches the interface.
// Notes:   Write beats are taken every cycle except in reset and the first cycle after it; read beats are returned one at a time.
// Functional notes
// - One poison bit per 64 data bits
// - Read, write, snoop poison drivers; ceil(W/64) wide
// - Poison present on every data channel
// - Poison meaningful only with valid data
// - Poison independent of error response
// - Granule is aligned 8-byte address range
// - Receiver combines narrow beats per granule
// - Poison allowed on unused byte lanes
// - No scheme means no check signals
// - Data scheme: one bit per data byte
// - All scheme: every signal is covered
// - Group plus check bit is odd
// - Critical control check is its inverse
// - Check bit n covers bits 8n+7:8n
// - Partial top byte gets short group
// - Drive check bits whenever enable true
// - Parity over all bits, used or not
// - Omit check with no covered signals
// - Absent covered signals count as low
// - Response never depends on parity error
// - Error: drop or forward, mark poisoned
// - Handshake checks after reset, payload with valid
`default_nettype none
module bus_guard_slave #(
  parameter int                         DATA_W      = 128,
  parameter bus_guard_pkg::check_type_e CHECK_TYPE  = bus_guard_pkg::CHK_ALL,
  parameter bit                         POISON_EN   = 1'b1,
  parameter bit                         FWD_ON_ERR  = 1'b1,
  parameter bit                         MARK_POISON = 1'b1
) (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  bus_guard_if.slv                               bus,
  output var  logic                              wr_valid,
  output var  logic [DATA_W-1:0]                 wr_data,
  output var  logic [DATA_W/8-1:0]               wr_strb,
  output var  logic                              wr_last,
  output var  logic [(DATA_W+63)/64-1:0]         wr_poison,
  output var  logic                              wr_err,
  input  wire logic                              rd_valid,
  output var  logic                              rd_ready,
  input  wire logic [DATA_W-1:0]                 rd_data,
  input  wire logic [bus_guard_pkg::RESP_W-1:0]  rd_resp,
  input  wire logic                              rd_last,
  input  wire logic [(DATA_W+63)/64-1:0]         rd_poison,
  output var  logic                              rr_err
);
  localparam int  DCW  = DATA_W / bus_guard_pkg::GROUP_W;
  localparam int  PW   = (DATA_W + bus_guard_pkg::GRAN_W - 1) / bus_guard_pkg::GRAN_W;
  localparam int  PCW  = (PW + bus_guard_pkg::GROUP_W - 1) / bus_guard_pkg::GROUP_W;
  localparam int  MW   = bus_guard_pkg::MAX_W;
  localparam bit  C_ON = (CHECK_TYPE != bus_guard_pkg::CHK_NONE);
  localparam bit  C_AL = (CHECK_TYPE == bus_guard_pkg::CHK_ALL);

  typedef enum logic [1:0] {
    R_IDLE = 2'h1,
    R_SEND = 2'h2
  } rd_state_e;

  typedef struct packed {
    logic              wready;
    logic              wready_chk;
    logic [PW-1:0]     acc;
    logic              wr_valid;
    logic [DATA_W-1:0] wr_data;
    logic [DCW-1:0]    wr_strb;
    logic              wr_last;
    logic [PW-1:0]     wr_poison;
    logic              wr_err;
    rd_state_e         rstate;
    logic              rvalid;
    logic              rvalid_chk;
    logic [DATA_W-1:0] rdata;
    logic [DCW-1:0]    rdata_chk;
    logic [1:0]        rresp;
    logic              rresp_chk;
    logic              rlast;
    logic              rlast_chk;
    logic [PW-1:0]     rpoison;
    logic [PCW-1:0]    rpoison_chk;
    logic              rd_ready;
    logic              rr_err;
  } slv_state_s;

  slv_state_s st_reg;
  slv_state_s st_next;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_d;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_s;
  logic [bus_guard_pkg::MAX_CHK-1:0] e_p;
  logic [bus_guard_pkg::MAX_CHK-1:0] o_d;
  logic [bus_guard_pkg::MAX_CHK-1:0] o_p;
  logic [PW-1:0]                     w_pois;
  logic                              w_take;
  logic                              hs_bad;
  logic                              pay_bad;

  // ----------------------------------------------------------------
  // Write channel receive and check
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.wr_valid = 1'b0;
    st_next.wready   = 1'b1;
    w_pois  = POISON_EN ? bus.wpoison : '0;
    e_d     = bus_guard_pkg::odd_chk(MW'(bus.wdata), DATA_W);
    e_s     = bus_guard_pkg::odd_chk(MW'(bus.wstrb), DCW);
    e_p     = bus_guard_pkg::odd_chk(MW'(w_pois), PW);
    hs_bad  = C_AL && ((bus.wvalid_chk == bus.wvalid) || (bus.rready_chk == bus.rready));
    pay_bad = (C_ON && (bus.wdata_chk != e_d[DCW-1:0]))
           || (C_AL && (bus.wstrb_chk != e_s[PW-1:0]))
           || (C_AL && (bus.wlast_chk == bus.wlast))
           || (C_AL && POISON_EN && (bus.wpoison_chk != e_p[PCW-1:0]));
    st_next.wr_err = hs_bad || (bus.wvalid && pay_bad);
    w_take = bus.wvalid && st_reg.wready;
    if (w_take)
    begin
      st_next.acc = bus.wlast ? '0 : (st_reg.acc | w_pois);
      if (FWD_ON_ERR || !pay_bad)
      begin
        st_next.wr_valid  = 1'b1;
        st_next.wr_data   = bus.wdata;
        st_next.wr_strb   = bus.wstrb;
        st_next.wr_last   = bus.wlast;
        st_next.wr_poison = st_reg.acc | w_pois;
        if (MARK_POISON && pay_bad)
        begin
          st_next.wr_poison = '1;
        end
      end
    end

    // ----------------------------------------------------------------
    // Read channel return
    // ----------------------------------------------------------------
    case (st_reg.rstate)
      R_IDLE:
      begin
        if (rd_valid && st_reg.rd_ready)
        begin
          st_next.rstate  = R_SEND;
          st_next.rvalid  = 1'b1;
          st_next.rdata   = rd_data;
          st_next.rresp   = rd_resp;
          st_next.rlast   = rd_last;
          st_next.rpoison = POISON_EN ? rd_poison : '0;
        end
      end
      R_SEND:
      begin
        if (bus.rready)
        begin
          st_next.rstate = R_IDLE;
          st_next.rvalid = 1'b0;
        end
      end
      default:
      begin
        st_next.rstate = R_IDLE;
        st_next.rvalid = 1'b0;
      end
    endcase
    st_next.rd_ready = (st_next.rstate == R_IDLE);
    o_d = bus_guard_pkg::odd_chk(MW'(st_next.rdata), DATA_W);
    o_p = bus_guard_pkg::odd_chk(MW'(st_next.rpoison), PW);
    st_next.wready_chk  = C_AL ? !st_next.wready : 1'b0;
    st_next.rvalid_chk  = C_AL ? !st_next.rvalid : 1'b0;
    st_next.rdata_chk   = C_ON ? o_d[DCW-1:0] : '0;
    st_next.rresp_chk   = C_AL ? !(^st_next.rresp) : 1'b0;
    st_next.rlast_chk   = C_AL ? !st_next.rlast : 1'b0;
    st_next.rpoison_chk = (C_AL && POISON_EN) ? o_p[PCW-1:0] : '0;
    st_next.rr_err      = C_AL && ((bus.rready_chk == bus.rready) || (bus.wvalid_chk == bus.wvalid));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg            <= '0;
      st_reg.rstate     <= R_IDLE;
      st_reg.wready_chk <= C_AL;
      st_reg.rvalid_chk <= C_AL;
      st_reg.rresp_chk  <= C_AL;
      st_reg.rlast_chk  <= C_AL;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.wready      = st_reg.wready;
  assign bus.wready_chk  = st_reg.wready_chk;
  assign bus.rvalid      = st_reg.rvalid;
  assign bus.rvalid_chk  = st_reg.rvalid_chk;
  assign bus.rdata       = st_reg.rdata;
  assign bus.rdata_chk   = st_reg.rdata_chk;
  assign bus.rresp       = st_reg.rresp;
  assign bus.rresp_chk   = st_reg.rresp_chk;
  assign bus.rlast       = st_reg.rlast;
  assign bus.rlast_chk   = st_reg.rlast_chk;
  assign bus.rpoison     = st_reg.rpoison;
  assign bus.rpoison_chk = st_reg.rpoison_chk;
  assign wr_valid        = st_reg.wr_valid;
  assign wr_data         = st_reg.wr_data;
  assign wr_strb         = st_reg.wr_strb;
  assign wr_last         = st_reg.wr_last;
  assign wr_poison       = st_reg.wr_poison;
  assign wr_err          = st_reg.wr_err;
  assign rd_ready        = st_reg.rd_ready;
  assign rr_err          = st_reg.rr_err;
endmodule // bus_guard_slave
`default_nettype wire

// ---- bus_guard_chk.sv ----
// Purpose: Assertions on the wires between the bus guard master and slave.
// Assumes: All-signals scheme with poison on at both ends.
// Notes:   Widths follow DATA_W as in the interface.
`default_nettype none
module bus_guard_chk #(
  parameter int  DATA_W = 128,
  localparam int DCW    = DATA_W / 8,
  localparam int PW     = (DATA_W + 63) / 64,
  localparam int PCW    = (PW + 7) / 8
) (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              wvalid,
  input wire logic              wvalid_chk,
  input wire logic              wready,
  input wire logic              wready_chk,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DCW-1:0]    wdata_chk,
  input wire logic [DCW-1:0]    wstrb,
  input wire logic [PW-1:0]     wstrb_chk,
  input wire logic              wlast,
  input wire logic              wlast_chk,
  input wire logic [PW-1:0]     wpoison,
  input wire logic [PCW-1:0]    wpoison_chk,
  input wire logic              rvalid,
  input wire logic              rvalid_chk,
  input wire logic              rready,
  input wire logic              rready_chk,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [DCW-1:0]    rdata_chk,
  input wire logic [1:0]        rresp,
  input wire logic              rresp_chk,
  input wire logic              rlast,
  input wire logic              rlast_chk,
  input wire logic [PW-1:0]     rpoison,
  input wire logic [PCW-1:0]    rpoison_chk
);
  timeunit 1ns / 1ps;
  // ------------------------------
  // Odd parity per byte group.
  // ------------------------------
  function automatic logic [DCW-1:0] par(input logic [DATA_W-1:0] v);
    logic [DCW-1:0] p;
    for (int i = 0; i < DCW; i++)
      p[i] = ~^v[8*i+:8];
    return p;
  endfunction
  logic [DCW-1:0] strb_p;
  logic [DCW-1:0] pois_p;
  assign strb_p = par(DATA_W'(wstrb));
  assign pois_p = par(DATA_W'(wpoison));
  logic [DCW-1:0] rpois_p;
  assign rpois_p = par(DATA_W'(rpoison));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence rd_take;
    rvalid && rready;
  endsequence
  wvalid_inv_a: assert property (wvalid_chk == !wvalid)
    else $error("wvalid check wrong");
  rvalid_inv_a: assert property (rvalid_chk == !rvalid)
    else $error("rvalid check wrong");
  ready_inv_a: assert property (wready_chk == !wready && rready_chk == !rready)
    else $error("ready check wrong");
  ready_up_a: assert property ($past(nrst) |-> wready && rready)
    else $error("ready low out of reset");
  wdata_par_a: assert property (wvalid |-> wdata_chk == par(wdata))
    else $error("wdata parity wrong");
  rdata_par_a: assert property (rvalid |-> rdata_chk == par(rdata))
    else $error("rdata parity wrong");
  wside_par_a: assert property (wvalid |-> wstrb_chk == strb_p[PW-1:0] && wpoison_chk == pois_p[PCW-1:0])
    else $error("wstrb or wpoison parity wrong");
  wlast_inv_a: assert property (wvalid |-> wlast_chk == !wlast)
    else $error("wlast check wrong");
  rresp_par_a: assert property (rvalid |-> rresp_chk == ~^rresp)
    else $error("rresp parity wrong");
  rd_accept_a: assert property (rd_take |=> !rvalid)
    else $error("rvalid held after accept");
  rside_par_a: assert property (rvalid |-> rlast_chk == !rlast && rpoison_chk == rpois_p[PCW-1:0])
    else $error("rlast or rpoison check wrong");
endmodule // bus_guard_chk
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the bus guard master and slave pair.
// Assumes: Both ends keep the all-signals scheme with poison on.
// Notes:   A second slave takes bench-driven wires carrying a parity fault.
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  localparam int DW = 72;
  logic          clk_sys, nrst, wr_valid, wr_ready, wr_last, rd_valid, rd_err;
  logic          sw_valid, sw_err, sr_valid, sr_ready, sr_last, fw_valid, fw_err;
  logic          sw_last, m_last, s_rrerr;
  logic [DW-1:0] wr_data, rd_data, sw_data, sr_data;
  logic [8:0]    wr_strb, sw_strb;
  logic [1:0]    wr_poison, rd_resp, rd_poison, sw_poison, sr_resp, sr_poison, fw_poison;
  int            err_count;
  int            checks;
  bus_guard_if #(.DATA_W(DW)) bif ();
  bus_guard_if #(.DATA_W(DW)) fif ();
  bus_guard_master #(.DATA_W(DW)) u_bus_guard_master (.clk_sys(clk_sys), .nrst(nrst), .bus(bif.mst),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_strb(wr_strb), .wr_last(wr_last),
    .wr_poison(wr_poison), .rd_valid(rd_valid), .rd_data(rd_data), .rd_resp(rd_resp), .rd_last(m_last),
    .rd_poison(rd_poison), .rd_err(rd_err));
  bus_guard_slave #(.DATA_W(DW)) u_bus_guard_slave (.clk_sys(clk_sys), .nrst(nrst), .bus(bif.slv),
    .wr_valid(sw_valid), .wr_data(sw_data), .wr_strb(sw_strb), .wr_last(sw_last),
    .wr_poison(sw_poison), .wr_err(sw_err),
    .rd_valid(sr_valid), .rd_ready(sr_ready), .rd_data(sr_data), .rd_resp(sr_resp), .rd_last(sr_last),
    .rd_poison(sr_poison), .rr_err(s_rrerr));
  bus_guard_slave #(.DATA_W(DW)) u_bus_guard_slave_f (.clk_sys(clk_sys), .nrst(nrst), .bus(fif.slv),
    .wr_valid(fw_valid), .wr_data(), .wr_strb(), .wr_last(), .wr_poison(fw_poison), .wr_err(fw_err),
    .rd_valid(1'b0), .rd_ready(), .rd_data(sr_data), .rd_resp(sr_resp), .rd_last(sr_last),
    .rd_poison(sr_poison), .rr_err());
  bus_guard_chk #(.DATA_W(DW)) u_bus_guard_chk (.clk_sys(clk_sys), .nrst(nrst), .wvalid(bif.wvalid),
    .wvalid_chk(bif.wvalid_chk), .wready(bif.wready), .wready_chk(bif.wready_chk), .wdata(bif.wdata),
    .wdata_chk(bif.wdata_chk), .wstrb(bif.wstrb), .wstrb_chk(bif.wstrb_chk), .wlast(bif.wlast),
    .wlast_chk(bif.wlast_chk), .wpoison(bif.wpoison), .wpoison_chk(bif.wpoison_chk), .rvalid(bif.rvalid),
    .rvalid_chk(bif.rvalid_chk), .rready(bif.rready), .rready_chk(bif.rready_chk), .rdata(bif.rdata),
    .rdata_chk(bif.rdata_chk), .rresp(bif.rresp), .rresp_chk(bif.rresp_chk), .rlast(bif.rlast),
    .rlast_chk(bif.rlast_chk), .rpoison(bif.rpoison), .rpoison_chk(bif.rpoison_chk));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ------------------------------
  // Shared checking and waiting.
  // ------------------------------
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? wr_ready : k == 1 ? sw_valid : k == 2 ? sr_ready : k == 3 ? rd_valid : fw_err;
  endfunction
  task automatic wait_on(input int k);
    for (int n = 0; pick(k) !== 1'b1; n++)
    begin
      err_count += int'(n == 20);
      if (n == 20)
        print_verdict();
      @(negedge clk_sys);
    end
  endtask
  task automatic wr_beat(input logic [DW-1:0] d, input logic [8:0] s, input logic l, input logic [1:0] p, e);
    wait_on(0);
    {wr_valid, wr_data, wr_strb, wr_last, wr_poison} = {1'b1, d, s, l, p};
    @(negedge clk_sys);
    wr_valid = 1'b0;
    wait_on(1);
    chk(sw_data, d);
    chk(DW'(sw_poison), DW'(e));
    chk(DW'(sw_err), '0);
    chk(DW'(sw_strb), DW'(s));
    chk(DW'(sw_last), DW'(l));
    @(negedge clk_sys);
  endtask
  task automatic rd_beat(input logic [DW-1:0] d, input logic [1:0] r, input logic [1:0] p, input logic l);
    wait_on(2);
    {sr_valid, sr_data, sr_resp, sr_poison, sr_last} = {1'b1, d, r, p, l};
    @(negedge clk_sys);
    sr_valid = 1'b0;
    wait_on(3);
    chk(rd_data, d);
    chk(DW'(rd_resp), DW'(r));
    chk(DW'(rd_poison), DW'(p));
    chk(DW'(rd_err), '0);
    chk(DW'(m_last), DW'(l));
    chk(DW'(s_rrerr), '0);
    @(negedge clk_sys);
  endtask
  // ------------------------------
  // Scenarios.
  // ------------------------------
  task automatic t_write();
    wr_beat({9{8'hA5}}, 9'h001, 1'b0, 2'h2, 2'h2);
    wr_beat({9{8'h3C}}, 9'h0FF, 1'b0, 2'h1, 2'h3);
    wr_beat({9{8'h81}}, 9'h1FF, 1'b1, 2'h0, 2'h3);
    wr_beat({9{8'h7E}}, 9'h100, 1'b1, 2'h1, 2'h1);
  endtask
  task automatic t_read();
    for (int i = 0; i < 4; i++)
    begin
      rd_beat({8{9'(i) * 9'h025 + 9'h001}}, 2'(i), 2'(3 - i), i == 3);
    end
  endtask
  task automatic t_fault();
    {fif.wvalid, fif.wvalid_chk, fif.wdata_chk} = {2'h2, 9'h1FB};
    @(negedge clk_sys);
    {fif.wvalid, fif.wvalid_chk, fif.wdata_chk} = {2'h1, 9'h1FF};
    wait_on(4);
    chk(DW'(fw_valid), DW'(1'b1));
    chk(DW'(fw_poison), DW'(2'h3));
    chk(DW'(fw_err), DW'(1'b1));
  endtask
  initial
  begin
    {err_count, checks, nrst, sr_last} = {64'h0, 2'h1};
    {wr_valid, wr_data, wr_strb, wr_last, wr_poison, sr_valid, sr_data, sr_resp, sr_poison} = '0;
    {fif.wvalid, fif.wvalid_chk, fif.wdata, fif.wdata_chk, fif.wstrb, fif.wstrb_chk} = {2'h1, 72'h0, 18'h3FFFF, 2'h1};
    {fif.wlast, fif.wlast_chk, fif.wpoison, fif.wpoison_chk, fif.rready, fif.rready_chk} = {4'h8, 1'b1, 2'h2};
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_write();
    t_read();
    t_fault();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
